// file: shared/spi_port_map.svh
`ifndef SPI_PORT_MAP_SVH
`define SPI_PORT_MAP_SVH
// --------------------------------------------------------------
// register indices, byte address is four times the index
// --------------------------------------------------------------
`define IDX_SERIAL_DATA 8'h3C
`define IDX_SERIAL_CONFIG 8'h3D
`define IDX_IRQ_STATUS 8'h3E
`define IDX_IRQ_MASK 8'h3F
`define IDX_PIN_CTRL 8'h40
// --------------------------------------------------------------
// serial_config fields
// --------------------------------------------------------------
`define CFG_SWAP 7
`define CFG_LSB_FIRST 6
`define CFG_ROLE_HI 5
`define CFG_ROLE_LO 4
`define CFG_CPOL 3
`define CFG_CPHA 2
`define CFG_DIV_HI 1
`define CFG_DIV_LO 0
// --------------------------------------------------------------
// status bits, pin control layout, reset values
// --------------------------------------------------------------
`define ST_TX_EMPTY 0
`define ST_RX_FULL 1
`define PIN_SCLK 0
`define PIN_SEL 1
`define PIN_MOSI 2
`define PIN_MISO 3
`define PC_USE_LO 0
`define PC_OE_LO 4
`define PC_VAL_LO 8
`define DATA_RESET 8'h00
`define CFG_RESET 8'h00
`define MASK_RESET 2'h0
`define PIN_CTRL_RESET 12'h000
// --------------------------------------------------------------
// half serial clock periods in processor clocks (divisor / 2)
// --------------------------------------------------------------
`define HALF_DIV_00 6'h03
`define HALF_DIV_01 6'h06
`define HALF_DIV_10 6'h18
`define HALF_DIV_11 6'h30
`define LAST_EDGE 4'hF
`define LAST_BIT 3'h7
// --------------------------------------------------------------
// interrupt priorities and vectors
// --------------------------------------------------------------
`define PRIO_TX_EMPTY 4'h3
`define VEC_TX_EMPTY 16'h000C
`define PRIO_RX_FULL 4'h4
`define VEC_RX_FULL 16'h0010
`define VEC_NONE 16'h0000
`endif

// file: shared/spi_port_pkg.sv
package spi_port_pkg;
  // role field of serial_config
  typedef enum logic [1:0] {
    ROLE_OFF = 2'h0,
    ROLE_MASTER = 2'h1,
    ROLE_SLAVE = 2'h2,
    ROLE_RSVD = 2'h3
  } role_t;
  // transfer state, one-hot
  typedef enum logic [1:0] {
    XS_IDLE = 2'b01,
    XS_RUN = 2'b10
  } xfer_state_t;
  typedef logic [15:0] vector_t;
endpackage

// file: rtl/sclk_divider.sv
`timescale 1ns/1ps
`include "spi_port_map.svh"
module sclk_divider
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  input wire logic [1:0] div_sel,
  // one-cycle pulse every half serial clock period
  output logic tick
);
  import spi_port_pkg::*;

  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  // half period for each divisor code
  function automatic logic [5:0] half_of(input logic [1:0] sel);
    case (sel)
      2'h0: half_of = `HALF_DIV_00;
      2'h1: half_of = `HALF_DIV_01;
      2'h2: half_of = `HALF_DIV_10;
      default: half_of = `HALF_DIV_11;
    endcase
  endfunction

  // counter restarts while stopped so the first edge has a full half period of setup
  always_comb
  begin
    cnt_nxt = cnt_r + 6'h01;
    tick_nxt = 1'b0;
    if (!run)
    begin
      cnt_nxt = 6'h00;
    end
    else if (cnt_r >= half_of(div_sel) - 6'h01)
    begin
      cnt_nxt = 6'h00;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= 6'h00;
      tick_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule

// file: rtl/spi_master_slave_port.sv
// The APB slave port was decided locally.
`timescale 1ns/1ps
`include "spi_port_map.svh"
module spi_master_slave_port
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq,
  output spi_port_pkg::vector_t irq_vector,
  // serial clock pin
  input wire logic sclk_pin_level,
  output logic sclk_pin_value,
  output logic sclk_pin_enable,
  // select pin
  input wire logic port1_bit4_pin_level,
  output logic port1_bit4_pin_value,
  output logic port1_bit4_pin_enable,
  // master-out data pin
  input wire logic master_out_data_pin_level,
  output logic master_out_data_pin_value,
  output logic master_out_data_pin_enable,
  // master-in data pin
  input wire logic master_in_data_pin_level,
  output logic master_in_data_pin_value,
  output logic master_in_data_pin_enable
);
  import spi_port_pkg::*;

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic out_bit(input logic [7:0] v, input logic lsb);
    out_bit = lsb ? v[0] : v[7];
  endfunction

  function automatic logic [7:0] shift_out(input logic [7:0] v, input logic lsb);
    shift_out = lsb ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b, input logic lsb);
    shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  function automatic logic word_is(input logic [11:0] a, input logic [7:0] idx);
    word_is = (a[1:0] == 2'h0) && (a[11:10] == 2'h0) && (a[9:2] == idx);
  endfunction

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  logic [7:0] cfg_r, cfg_nxt;
  logic [1:0] mask_r, mask_nxt;
  logic [11:0] pinc_r, pinc_nxt;
  logic [1:0] stat_r, stat_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic irq_r, irq_nxt;
  vector_t vec_r, vec_nxt;
  logic [7:0] hold_r, hold_nxt;
  logic hold_full_r, hold_full_nxt;
  logic [7:0] rxbuf_r, rxbuf_nxt;
  logic rx_avail_r, rx_avail_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [7:0] rxsh_r, rxsh_nxt;
  logic dout_r, dout_nxt;
  logic [3:0] edge_cnt_r, edge_cnt_nxt;
  logic [2:0] bits_r, bits_nxt;
  xfer_state_t st_r, st_nxt;
  logic sclk_r, sclk_nxt;
  logic sel_r, sel_nxt;
  logic sclk_q_r, sel_q_r;
  logic [3:0] pin_val_r, pin_val_nxt;
  logic [3:0] pin_en_r, pin_en_nxt;

  role_t role;
  logic master, slave, lsb, cpha, out_is_mosi, din;
  logic div_tick, m_edge, s_edge, any_edge, sample, load, byte_done;
  logic tx_event, rx_event, setup, done, wr, rd;

  // --------------------------------------------------------------
  // role decode and edge detection
  // --------------------------------------------------------------
  // reserved role code behaves as off
  assign role = role_t'(cfg_r[`CFG_ROLE_HI:`CFG_ROLE_LO]);
  assign master = (role == ROLE_MASTER);
  assign slave = (role == ROLE_SLAVE);
  assign lsb = cfg_r[`CFG_LSB_FIRST];
  assign cpha = cfg_r[`CFG_CPHA];
  assign out_is_mosi = master ^ cfg_r[`CFG_SWAP];
  assign din = out_is_mosi ? master_in_data_pin_level : master_out_data_pin_level;

  sclk_divider u_div
  (
    .pclk(pclk),
    .presetn(presetn),
    .run(master && (st_r == XS_RUN)),
    .div_sel(cfg_r[`CFG_DIV_HI:`CFG_DIV_LO]),
    .tick(div_tick)
  );

  // shifting happens on serial clock edges, whatever the processor rate, except the first bit taken at load when phase is 0
  assign m_edge = master && (st_r == XS_RUN) && div_tick;
  // slave ignores the divider and follows the partner's clock while selected
  assign s_edge = slave && (st_r == XS_RUN) && !port1_bit4_pin_level
                  && (sclk_pin_level != sclk_q_r);
  assign any_edge = m_edge || s_edge;
  // even edge counts are leading edges; phase decides which one samples
  assign sample = any_edge && ((edge_cnt_r[0] == 1'b0) ^ cpha);
  assign byte_done = any_edge && (edge_cnt_r == `LAST_EDGE);

  // --------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------
  // no wait state; prdata and pready come straight from flops loaded in the setup cycle
  assign setup = psel && !penable;
  assign done = psel && penable && pready_r;
  assign wr = done && pwrite && !pslverr_r;
  assign rd = done && !pwrite && !pslverr_r;

  // --------------------------------------------------------------
  // transfer engine
  // --------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    rxsh_nxt = rxsh_r;
    dout_nxt = dout_r;
    edge_cnt_nxt = edge_cnt_r;
    bits_nxt = bits_r;
    sclk_nxt = sclk_r;
    sel_nxt = 1'b1;
    rxbuf_nxt = rxbuf_r;
    rx_event = 1'b0;
    load = 1'b0;
    if (any_edge)
    begin
      edge_cnt_nxt = edge_cnt_r + 4'h1;
    end
    // output bit changes on the non-sampling edge
    if (any_edge && !sample)
    begin
      dout_nxt = out_bit(sh_r, lsb);
      sh_nxt = shift_out(sh_r, lsb);
    end
    if (sample)
    begin
      rxsh_nxt = shift_in(rxsh_r, din, lsb);
      bits_nxt = bits_r + 3'h1;
      if (bits_r == `LAST_BIT)
      begin
        rxbuf_nxt = shift_in(rxsh_r, din, lsb);
        rx_event = 1'b1;
      end
    end
    case (st_r)
      XS_IDLE:
      begin
        sclk_nxt = cfg_r[`CFG_CPOL];
        edge_cnt_nxt = 4'h0;
        bits_nxt = 3'h0;
        if (master && hold_full_r)
        begin
          load = 1'b1;
          st_nxt = XS_RUN;
          sel_nxt = 1'b0;
        end
        else if (slave && !port1_bit4_pin_level && sel_q_r)
        begin
          load = 1'b1;
          st_nxt = XS_RUN;
        end
      end
      XS_RUN:
      begin
        sel_nxt = !master;
        if (m_edge)
        begin
          sclk_nxt = !sclk_r;
        end
        if (!master && !slave)
        begin
          st_nxt = XS_IDLE;
        end
        else if (slave && port1_bit4_pin_level)
        begin
          // deselect aborts a partial byte
          st_nxt = XS_IDLE;
        end
        else if (byte_done && hold_full_r)
        begin
          load = 1'b1;
        end
        else if (byte_done && master)
        begin
          st_nxt = XS_IDLE;
          sel_nxt = 1'b1;
        end
      end
      default:
      begin
        st_nxt = XS_IDLE;
      end
    endcase
    // holding register moves to the shifter; an empty holding sends the shifter's leftover bits, zeros after a full byte
    if (load && hold_full_r)
    begin
      sh_nxt = hold_r;
      if (!cpha)
      begin
        dout_nxt = out_bit(hold_r, lsb);
        sh_nxt = shift_out(hold_r, lsb);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= XS_IDLE;
      sh_r <= `DATA_RESET;
      rxsh_r <= `DATA_RESET;
      rxbuf_r <= `DATA_RESET;
      dout_r <= 1'b0;
      edge_cnt_r <= 4'h0;
      bits_r <= 3'h0;
      sclk_r <= 1'b0;
      sel_r <= 1'b1;
      sclk_q_r <= 1'b0;
      sel_q_r <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      rxsh_r <= rxsh_nxt;
      rxbuf_r <= rxbuf_nxt;
      dout_r <= dout_nxt;
      edge_cnt_r <= edge_cnt_nxt;
      bits_r <= bits_nxt;
      sclk_r <= sclk_nxt;
      sel_r <= sel_nxt;
      sclk_q_r <= sclk_pin_level;
      sel_q_r <= port1_bit4_pin_level;
    end
  end

  // --------------------------------------------------------------
  // registers, buffers and interrupts
  // --------------------------------------------------------------
  always_comb
  begin
    cfg_nxt = cfg_r;
    mask_nxt = mask_r;
    pinc_nxt = pinc_r;
    hold_nxt = hold_r;
    tx_event = load && hold_full_r;
    // a fresh write wins over the shifter taking the old byte
    hold_full_nxt = hold_full_r && !load;
    pready_nxt = setup;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h0000_0000;
    if (setup)
    begin
      pslverr_nxt = !(word_is(paddr, `IDX_SERIAL_DATA) || word_is(paddr, `IDX_SERIAL_CONFIG)
                      || word_is(paddr, `IDX_IRQ_STATUS) || word_is(paddr, `IDX_IRQ_MASK)
                      || word_is(paddr, `IDX_PIN_CTRL));
      if (word_is(paddr, `IDX_SERIAL_DATA))
        prdata_nxt = {24'h00_0000, rxbuf_r};
      if (word_is(paddr, `IDX_SERIAL_CONFIG))
        prdata_nxt = {24'h00_0000, cfg_r};
      if (word_is(paddr, `IDX_IRQ_STATUS))
        prdata_nxt = {27'h000_0000, st_r == XS_RUN, rx_avail_r, hold_full_r, stat_r};
      if (word_is(paddr, `IDX_IRQ_MASK))
        prdata_nxt = {30'h0000_0000, mask_r};
      if (word_is(paddr, `IDX_PIN_CTRL))
        prdata_nxt = {20'h0_0000, pinc_r};
    end
    // write cycles return zero rather than a stale copy of the register
    if (pwrite)
      prdata_nxt = 32'h0000_0000;
    if (wr && word_is(paddr, `IDX_SERIAL_DATA))
    begin
      hold_nxt = pwdata[7:0];
      hold_full_nxt = 1'b1;
    end
    if (wr && word_is(paddr, `IDX_SERIAL_CONFIG))
      cfg_nxt = pwdata[7:0];
    if (wr && word_is(paddr, `IDX_IRQ_MASK))
      mask_nxt = pwdata[1:0];
    if (wr && word_is(paddr, `IDX_PIN_CTRL))
      pinc_nxt = pwdata[11:0];
    // reading the data word empties the receive buffer; a new byte wins
    rx_avail_nxt = (rx_avail_r && !(rd && word_is(paddr, `IDX_SERIAL_DATA))) || rx_event;
    // write one to clear, a same-cycle event wins
    stat_nxt = stat_r;
    if (wr && word_is(paddr, `IDX_IRQ_STATUS))
      stat_nxt = stat_r & ~pwdata[1:0];
    stat_nxt[`ST_TX_EMPTY] = stat_nxt[`ST_TX_EMPTY] || tx_event;
    stat_nxt[`ST_RX_FULL] = stat_nxt[`ST_RX_FULL] || rx_event;
    irq_nxt = |(stat_nxt & mask_nxt);
    // lower priority number wins the vector
    vec_nxt = `VEC_NONE;
    if (stat_nxt[`ST_RX_FULL] && mask_nxt[`ST_RX_FULL])
      vec_nxt = `VEC_RX_FULL;
    if (stat_nxt[`ST_TX_EMPTY] && mask_nxt[`ST_TX_EMPTY])
      vec_nxt = `VEC_TX_EMPTY;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_r <= `CFG_RESET;
      mask_r <= `MASK_RESET;
      pinc_r <= `PIN_CTRL_RESET;
      stat_r <= 2'h0;
      hold_r <= `DATA_RESET;
      hold_full_r <= 1'b0;
      rx_avail_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      irq_r <= 1'b0;
      vec_r <= `VEC_NONE;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      mask_r <= mask_nxt;
      pinc_r <= pinc_nxt;
      stat_r <= stat_nxt;
      hold_r <= hold_nxt;
      hold_full_r <= hold_full_nxt;
      rx_avail_r <= rx_avail_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_r <= irq_nxt;
      vec_r <= vec_nxt;
    end
  end

  // --------------------------------------------------------------
  // pin multiplexing
  // --------------------------------------------------------------
  always_comb
  begin
    pin_en_nxt = pinc_r[`PC_OE_LO +: 4];
    pin_val_nxt = pinc_r[`PC_VAL_LO +: 4];
    if (master || slave)
    begin
      if (pinc_r[`PC_USE_LO + `PIN_SCLK])
      begin
        pin_en_nxt[`PIN_SCLK] = master;
        pin_val_nxt[`PIN_SCLK] = sclk_r;
      end
      // select direction stays with firmware, only its value is taken over
      if (pinc_r[`PC_USE_LO + `PIN_SEL])
        pin_val_nxt[`PIN_SEL] = sel_r;
      // slave drives its output line only while selected
      if (pinc_r[`PC_USE_LO + `PIN_MOSI])
      begin
        pin_en_nxt[`PIN_MOSI] = out_is_mosi && (master || !port1_bit4_pin_level);
        pin_val_nxt[`PIN_MOSI] = dout_r;
      end
      if (pinc_r[`PC_USE_LO + `PIN_MISO])
      begin
        pin_en_nxt[`PIN_MISO] = !out_is_mosi && (master || !port1_bit4_pin_level);
        pin_val_nxt[`PIN_MISO] = dout_r;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_en_r <= 4'h0;
      pin_val_r <= 4'h0;
    end
    else
    begin
      pin_en_r <= pin_en_nxt;
      pin_val_r <= pin_val_nxt;
    end
  end

  // four pins only
  assign sclk_pin_value = pin_val_r[`PIN_SCLK];
  assign sclk_pin_enable = pin_en_r[`PIN_SCLK];
  assign port1_bit4_pin_value = pin_val_r[`PIN_SEL];
  assign port1_bit4_pin_enable = pin_en_r[`PIN_SEL];
  assign master_out_data_pin_value = pin_val_r[`PIN_MOSI];
  assign master_out_data_pin_enable = pin_en_r[`PIN_MOSI];
  assign master_in_data_pin_value = pin_val_r[`PIN_MISO];
  assign master_in_data_pin_enable = pin_en_r[`PIN_MISO];
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign irq_vector = vec_r;

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_data_write;
    psel && penable && pready && pwrite && word_is(paddr, `IDX_SERIAL_DATA);
  endsequence
  sequence s_fast_tick;
    div_tick && master && cfg_r[`CFG_DIV_HI:`CFG_DIV_LO] == 2'h0;
  endsequence

  a_hold_load: assert property (s_data_write |=> hold_full_r)
    else $error("data write did not fill holding register");
  a_rx_flag: assert property (rx_event |=> stat_r[`ST_RX_FULL] && rx_avail_r)
    else $error("received byte did not set flag");
  a_tx_flag: assert property (tx_event |=> stat_r[`ST_TX_EMPTY]
                              && (irq || !mask_r[`ST_TX_EMPTY]))
    else $error("holding empty did not raise interrupt");
  a_div_spacing: assert property (s_fast_tick |=> !div_tick [*2])
    else $error("fastest divider ticks too soon");
  a_idle_level: assert property ((st_r == XS_IDLE) [*2] |-> sclk_r == $past(cfg_r[`CFG_CPOL]))
    else $error("serial clock not at idle level");
  a_off_pins: assert property (!master && !slave |=> pin_en_r == $past(pinc_r[`PC_OE_LO +: 4]))
    else $error("disabled port drives pins");
  a_swap_dir: assert property (master && !cfg_r[`CFG_SWAP] && pinc_r[`PIN_MISO]
                                |=> !master_in_data_pin_enable)
    else $error("master drives its input line");
  a_lsb_load: assert property (load && hold_full_r && !cpha && lsb |=> dout_r == $past(hold_r[0]))
    else $error("first bit not lsb");
  a_vector_prio: assert property (irq_nxt && stat_nxt[0] && mask_nxt[0]
                                   |=> irq_vector == `VEC_TX_EMPTY)
    else $error("transmit-empty vector lost priority");
  a_slave_clk: assert property (slave && pinc_r[`PC_USE_LO + `PIN_SCLK]
                                |-> !m_edge ##1 !sclk_pin_enable)
    else $error("slave generated its own clock");
endmodule

// file: test/spi_far_model.sv
`timescale 1ns/1ps
// --------------------------------------------------------------
// far-side slave: mode 0, msb first, fixed reply byte
// --------------------------------------------------------------
module spi_far_model
(
  // link pins
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic mosi,
  output logic miso,
  // reply and capture
  input wire logic [7:0] reply,
  output logic [7:0] got
);
  logic [2:0] cnt;
  logic last = 1'b0;
  // bit counter moves on the launch edge and clears while deselected
  always @(negedge sclk or posedge sel_n)
    if (sel_n) cnt <= 3'h0;
    else cnt <= cnt + 3'h1;
  // capture on the leading edge
  always @(posedge sclk)
    if (!sel_n) got <= {got[6:0], mosi};
  // a released line shows the inverse of its last bit, never a stale copy
  always @(sel_n or cnt)
    if (!sel_n) last = reply[3'h7 - cnt];
  assign miso = sel_n ? ~last : reply[3'h7 - cnt];
endmodule

// file: test/spi_master_slave_port_tb.sv
`timescale 1ns/1ps
module spi_master_slave_port_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, irq, e;
  logic [15:0] irq_vector;
  logic sck, sck_en, sel, sel_en, mo, mo_en, mi, mi_v, mi_en;
  logic [7:0] reply = 8'h5A;
  logic [7:0] got;
  logic [7:0] srx;
  logic ext_sck = 1'b0;
  logic ext_sel = 1'b1;
  logic ext_mosi = 1'b0;
  logic sck_l, sel_l, mo_l;
  int error_cnt = 0;
  int checks_done = 0;
  int edges = 0;
  // --------------------------------------------------------------
  // clock, design and far side
  // --------------------------------------------------------------
  initial forever #10 pclk = ~pclk;
  always @(posedge sck) edges++;
  // the clock, select and master-out pins follow the bench acting as far-side master when the design does not drive them
  assign sck_l = sck_en ? sck : ext_sck;
  assign sel_l = sel_en ? sel : ext_sel;
  assign mo_l = mo_en ? mo : ext_mosi;
  spi_master_slave_port spi_master_slave_port_i (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .irq_vector(irq_vector),
    .sclk_pin_level(sck_l), .sclk_pin_value(sck), .sclk_pin_enable(sck_en),
    .port1_bit4_pin_level(sel_l), .port1_bit4_pin_value(sel), .port1_bit4_pin_enable(sel_en),
    .master_out_data_pin_level(mo_l), .master_out_data_pin_value(mo),
    .master_out_data_pin_enable(mo_en), .master_in_data_pin_level(mi),
    .master_in_data_pin_value(mi_v), .master_in_data_pin_enable(mi_en));
  spi_far_model spi_far_model_i (.sclk(sck), .sel_n(sel), .mosi(mo), .miso(mi),
    .reply(reply), .got(got));
  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20)
    begin
      error_cnt++;
      close_out();
    end
  endtask
  // bounded wait for the interrupt line
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 3000)
    begin
      error_cnt++;
      close_out();
    end
  endtask
  // one full master byte; expects tx-empty then rx-full
  task automatic xfer(input logic [7:0] tx, input logic [7:0] exp_rx, input logic [7:0] exp_got);
    edges = 0;
    apb(1'b1, 12'h0F0, {24'h0, tx});
    wait_irq();
    chk("tx vector", irq_vector, 32'h000C);
    apb(1'b1, 12'h0F8, 32'h1);
    wait_irq();
    chk("rx vector", irq_vector, 32'h0010);
    apb(1'b0, 12'h0F0, 32'h0);
    chk("rx data", q, {24'h0, exp_rx});
    apb(1'b1, 12'h0F8, 32'h2);
    repeat (60) @(posedge pclk);
    chk("far got", got, exp_got);
    chk("clock edges", edges, 32'd8);
    chk("irq clear", irq, 1'b0);
  endtask
  // one slave byte clocked by the bench, mode 0, msb first, four pclk per half period
  task automatic slave_byte(input logic [7:0] tx, output logic [7:0] rx);
    ext_sel <= 1'b0;
    repeat (4) @(posedge pclk);
    for (int i = 7; i >= 0; i--)
    begin
      ext_mosi <= tx[i];
      repeat (4) @(posedge pclk);
      rx[i] = mi_v;
      ext_sck <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_sck <= 1'b0;
    end
    repeat (4) @(posedge pclk);
    ext_sel <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h0F4, 32'h0);
    chk("config reset", q, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk("pin reset", q, 32'h0);
    apb(1'b0, 12'h104, 32'h0);
    chk("unmapped", e, 1'b1);
    apb(1'b1, 12'h100, 32'h02F);
    apb(1'b1, 12'h0F4, 32'h00);
    chk("off clock oe", sck_en, 1'b0);
    apb(1'b1, 12'h0F4, 32'h18);
    repeat (2) @(posedge pclk);
    chk("idle high", sck, 1'b1);
    apb(1'b1, 12'h0F4, 32'h90);
    repeat (2) @(posedge pclk);
    chk("swap mi oe", mi_en, 1'b1);
    chk("swap mo oe", mo_en, 1'b0);
    apb(1'b1, 12'h0F4, 32'h10);
    chk("config read", q, 32'h0);
    apb(1'b0, 12'h0F4, 32'h0);
    chk("config back", q, 32'h10);
    chk("clock oe", sck_en, 1'b1);
    chk("mo oe", mo_en, 1'b1);
    chk("idle low", sck, 1'b0);
    apb(1'b1, 12'h0F8, 32'h3);
    apb(1'b1, 12'h0FC, 32'h3);
    xfer(8'hC3, 8'h5A, 8'hC3);
    reply <= 8'h35;
    apb(1'b1, 12'h0F4, 32'h53);
    xfer(8'h01, 8'hAC, 8'h80);
    // slave role with the slowest divider code, which the slave must ignore
    apb(1'b1, 12'h100, 32'h00F);
    apb(1'b1, 12'h0F4, 32'h23);
    apb(1'b1, 12'h0F0, 32'hA5);
    slave_byte(8'h3C, srx);
    chk("slave tx", srx, 32'hA5);
    apb(1'b0, 12'h0F0, 32'h0);
    chk("slave rx", q, 32'h3C);
    close_out();
  end
endmodule
